// [isr_pkg.sv]
// Summary of operation
// - There are two independent groups, operation and questionable, each with condition, enable, event, falling filter and rising filter.
// - Operation condition shows constant current at bit 10, constant voltage at bit 8, trigger wait at bit 5, others unused.
// - Operation condition is read-only and shows the live, unlatched state when read.
// - Status bit 7 is the OR of operation event bits whose enable bit is set.
// - Operation enable is read/write, accepts 0 to 32727, and resets to zero.
// - Operation event is read-only and latches each enabled event that passes the transition filters.
// - Reading operation event returns its contents and then clears it.
// - A set falling filter bit makes a 1-to-0 change of the enabled condition bit set the event bit.
// - A set rising filter bit makes a 0-to-1 change of the enabled condition bit set the event bit.
// - Writing a filter bit to 1 while the condition already sits in the detected state sets the event bit at once.
// - Both filter registers are read/write, accept 0 to 32727, and reset to zero.
// - Preset clears falling filters and enables in both groups and loads rising filters with 1313 and 1555.
// - Questionable condition shows unregulated at bit 10, remote inhibit at 9, thermal at 4, overcurrent at 1, overvoltage at 0.
// - Questionable condition is read-only and shows the live, unlatched state when read.
// - Status bit 3 is the OR of questionable event bits whose enable bit is set.
package isr_pkg;
   localparam int REG_W = 16;
   localparam logic [15:0] VALUE_MAX = 16'h7fd7; // 32727
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [15:0] OP_RISE_PRESET = 16'h0521; // 1313
   localparam logic [15:0] QU_RISE_PRESET = 16'h0613; // 1555
   // Condition bit positions
   localparam int OP_CC_BIT = 10;
   localparam int OP_CV_BIT = 8;
   localparam int OP_WTG_BIT = 5;
   localparam int QU_UNR_BIT = 10;
   localparam int QU_RI_BIT = 9;
   localparam int QU_OT_BIT = 4;
   localparam int QU_OC_BIT = 1;
   localparam int QU_OV_BIT = 0;
   localparam logic [15:0] OP_USED = 16'h0520;
   localparam logic [15:0] QU_USED = 16'h0613;

   typedef enum logic [1:0] {
      ISR_OP_NONE = 2'b00,
      ISR_OP_READ = 2'b01,
      ISR_OP_WRITE = 2'b10,
      ISR_OP_PRESET = 2'b11
   } isr_op_t;

   typedef enum logic [3:0] {
      ISR_OP_COND = 4'h0,
      ISR_OP_ENAB = 4'h1,
      ISR_OP_EVENT = 4'h2,
      ISR_OP_FALL = 4'h3,
      ISR_OP_RISE = 4'h4,
      ISR_QU_COND = 4'h5,
      ISR_QU_ENAB = 4'h6,
      ISR_QU_EVENT = 4'h7,
      ISR_QU_FALL = 4'h8,
      ISR_QU_RISE = 4'h9
   } isr_sel_t;

   typedef struct packed {
      isr_op_t op;
      isr_sel_t sel;
      logic [15:0] wdata;
   } isr_cmd_t;

   typedef struct packed {
      logic [15:0] sync1;
      logic [15:0] sync2;
      logic [15:0] prev;
      logic [15:0] enable;
      logic [15:0] event_bits;
      logic [15:0] fall;
      logic [15:0] rise;
   } isr_grp_t;

   typedef struct packed {
      isr_grp_t op;
      isr_grp_t qu;
      logic rd_valid;
      logic [15:0] rd_data;
      logic op_summary;
      logic qu_summary;
   } isr_state_t;
endpackage : isr_pkg

// [isr_status.sv]
`timescale 1ns/100ps
`default_nettype none
module isr_status (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_cmd_valid,
   input wire isr_pkg::isr_cmd_t i_cmd,
   input wire logic i_constant_current_flag,
   input wire logic i_constant_voltage_flag,
   input wire logic i_trigger_wait_flag,
   input wire logic i_regulation_lost_flag,
   input wire logic i_remote_inhibit_flag,
   input wire logic i_thermal_trip_flag,
   input wire logic i_current_limit_trip,
   input wire logic i_high_voltage_trip,
   output logic o_rd_valid,
   output logic [15:0] o_rd_data,
   output logic o_op_summary,
   output logic o_qu_summary
);
   isr_pkg::isr_state_t state_ff;
   isr_pkg::isr_state_t nxt_state;
   logic [15:0] op_pins;
   logic [15:0] qu_pins;

   // Pack pin flags; unused positions stay zero
   always_comb begin
      op_pins = '0;
      op_pins[isr_pkg::OP_CC_BIT] = i_constant_current_flag;
      op_pins[isr_pkg::OP_CV_BIT] = i_constant_voltage_flag;
      op_pins[isr_pkg::OP_WTG_BIT] = i_trigger_wait_flag;
      qu_pins = '0;
      qu_pins[isr_pkg::QU_UNR_BIT] = i_regulation_lost_flag;
      qu_pins[isr_pkg::QU_RI_BIT] = i_remote_inhibit_flag;
      qu_pins[isr_pkg::QU_OT_BIT] = i_thermal_trip_flag;
      qu_pins[isr_pkg::QU_OC_BIT] = i_current_limit_trip;
      qu_pins[isr_pkg::QU_OV_BIT] = i_high_voltage_trip;
   end

   // One group's next state
   function automatic isr_pkg::isr_grp_t grp_next(
      input isr_pkg::isr_grp_t g,
      input logic [15:0] pins,
      input logic [15:0] used,
      input logic [15:0] rise_preset,
      input logic preset,
      input logic wr_enab,
      input logic wr_fall,
      input logic wr_rise,
      input logic rd_event,
      input logic [15:0] wdata
   );
      isr_pkg::isr_grp_t n;
      logic [15:0] rose;
      logic [15:0] fell;
      logic [15:0] hits;
      logic ok;
      n = g;
      ok = (wdata <= isr_pkg::VALUE_MAX);
      n.sync1 = pins & used;
      n.sync2 = g.sync1;
      n.prev = g.sync2;
      rose = g.sync2 & ~g.prev;
      fell = ~g.sync2 & g.prev;
      hits = g.enable & ((g.rise & rose) | (g.fall & fell));
      // Filter write while condition already matches
      if (wr_rise && ok) begin
         hits = hits | (g.enable & wdata & g.sync2);
      end
      if (wr_fall && ok) begin
         hits = hits | (g.enable & wdata & ~g.sync2 & used);
      end
      if (wr_enab && ok) begin
         n.enable = wdata;
      end
      if (wr_fall && ok) begin
         n.fall = wdata;
      end
      if (wr_rise && ok) begin
         n.rise = wdata;
      end
      if (preset) begin
         n.enable = isr_pkg::MASK_RESET;
         n.fall = isr_pkg::MASK_RESET;
         n.rise = rise_preset;
      end
      // Clear on read, new events win
      n.event_bits = (rd_event ? isr_pkg::MASK_RESET : g.event_bits) | (hits & used);
      return n;
   endfunction : grp_next

   // Command decode and both groups
   always_comb begin
      logic rd;
      logic wr;
      logic pre;
      rd = i_cmd_valid && (i_cmd.op == isr_pkg::ISR_OP_READ);
      wr = i_cmd_valid && (i_cmd.op == isr_pkg::ISR_OP_WRITE);
      pre = i_cmd_valid && (i_cmd.op == isr_pkg::ISR_OP_PRESET);
      nxt_state = state_ff;
      nxt_state.op = grp_next(state_ff.op, op_pins, isr_pkg::OP_USED, isr_pkg::OP_RISE_PRESET, pre,
         wr && (i_cmd.sel == isr_pkg::ISR_OP_ENAB), wr && (i_cmd.sel == isr_pkg::ISR_OP_FALL),
         wr && (i_cmd.sel == isr_pkg::ISR_OP_RISE), rd && (i_cmd.sel == isr_pkg::ISR_OP_EVENT), i_cmd.wdata);
      nxt_state.qu = grp_next(state_ff.qu, qu_pins, isr_pkg::QU_USED, isr_pkg::QU_RISE_PRESET, pre,
         wr && (i_cmd.sel == isr_pkg::ISR_QU_ENAB), wr && (i_cmd.sel == isr_pkg::ISR_QU_FALL),
         wr && (i_cmd.sel == isr_pkg::ISR_QU_RISE), rd && (i_cmd.sel == isr_pkg::ISR_QU_EVENT), i_cmd.wdata);
      nxt_state.rd_valid = rd;
      nxt_state.rd_data = '0;
      if (rd) begin
         case (i_cmd.sel)
            isr_pkg::ISR_OP_COND: nxt_state.rd_data = state_ff.op.sync2;
            isr_pkg::ISR_OP_ENAB: nxt_state.rd_data = state_ff.op.enable;
            isr_pkg::ISR_OP_EVENT: nxt_state.rd_data = state_ff.op.event_bits;
            isr_pkg::ISR_OP_FALL: nxt_state.rd_data = state_ff.op.fall;
            isr_pkg::ISR_OP_RISE: nxt_state.rd_data = state_ff.op.rise;
            isr_pkg::ISR_QU_COND: nxt_state.rd_data = state_ff.qu.sync2;
            isr_pkg::ISR_QU_ENAB: nxt_state.rd_data = state_ff.qu.enable;
            isr_pkg::ISR_QU_EVENT: nxt_state.rd_data = state_ff.qu.event_bits;
            isr_pkg::ISR_QU_FALL: nxt_state.rd_data = state_ff.qu.fall;
            isr_pkg::ISR_QU_RISE: nxt_state.rd_data = state_ff.qu.rise;
            default: nxt_state.rd_data = '0;
         endcase
      end
      nxt_state.op_summary = |(nxt_state.op.event_bits & nxt_state.op.enable);
      nxt_state.qu_summary = |(nxt_state.qu.event_bits & nxt_state.qu.enable);
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign o_rd_valid = state_ff.rd_valid;
   assign o_rd_data = state_ff.rd_data;
   assign o_op_summary = state_ff.op_summary;
   assign o_qu_summary = state_ff.qu_summary;
endmodule : isr_status
`default_nettype wire

// [isr_status_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module isr_status_checker (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_cmd_valid,
   input wire isr_pkg::isr_cmd_t i_cmd,
   input wire logic o_rd_valid,
   input wire logic [15:0] o_rd_data,
   input wire logic o_op_summary,
   input wire logic o_qu_summary
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // Decoded command strobes
   wire logic rd = i_cmd_valid && i_cmd.op == isr_pkg::ISR_OP_READ;
   wire logic pre = i_cmd_valid && i_cmd.op == isr_pkg::ISR_OP_PRESET;
   wire logic wen = i_cmd_valid && i_cmd.op == isr_pkg::ISR_OP_WRITE && i_cmd.sel == isr_pkg::ISR_OP_ENAB;
   // Read answers and register contents
   a_read_answer: assert property (rd |=> o_rd_valid) else $error("read not answered");
   a_no_stray_answer: assert property (!rd |=> !o_rd_valid) else $error("answer without read");
   a_op_unused_zero: assert property (rd && i_cmd.sel inside {isr_pkg::ISR_OP_COND, isr_pkg::ISR_OP_EVENT}
      |=> (o_rd_data & ~isr_pkg::OP_USED) == 16'h0000) else $error("op unused bit set");
   a_qu_unused_zero: assert property (rd && i_cmd.sel inside {isr_pkg::ISR_QU_COND, isr_pkg::ISR_QU_EVENT}
      |=> (o_rd_data & ~isr_pkg::QU_USED) == 16'h0000) else $error("qu unused bit set");
   a_enab_readback: assert property (wen && i_cmd.wdata <= isr_pkg::VALUE_MAX ##2 rd && i_cmd.sel == isr_pkg::ISR_OP_ENAB
      |=> o_rd_data == $past(i_cmd.wdata, 3)) else $error("enable readback");
   a_preset_rise: assert property (pre ##2 rd && i_cmd.sel == isr_pkg::ISR_OP_RISE
      |=> o_rd_data == isr_pkg::OP_RISE_PRESET) else $error("op rise preset");
   a_preset_qrise: assert property (pre ##4 rd && i_cmd.sel == isr_pkg::ISR_QU_RISE
      |=> o_rd_data == isr_pkg::QU_RISE_PRESET) else $error("qu rise preset");
   a_preset_quiet: assert property (pre ##1 !i_cmd_valid |=> !o_op_summary && !o_qu_summary)
      else $error("summary after preset");
endmodule : isr_status_checker
bind isr_status isr_status_checker u_chk (.i_clk, .i_resetn, .i_cmd_valid, .i_cmd, .o_rd_valid, .o_rd_data,
   .o_op_summary, .o_qu_summary);
`default_nettype wire

// [isr_status_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin failures++; \
   $display("wrong value %s exp %h got %h", n, e, a); end end
module isr_status_tb;
   logic i_clk, i_resetn, i_cmd_valid, o_rd_valid, o_op_summary, o_qu_summary;
   isr_pkg::isr_cmd_t i_cmd;
   logic [15:0] o_rd_data, v;
   logic [7:0] fl;
   logic [31:0] seed = 32'h0000_b44d;
   int failures = 0, n_tests = 0;
   isr_pkg::isr_sel_t rw [6] = '{isr_pkg::ISR_OP_ENAB, isr_pkg::ISR_OP_FALL, isr_pkg::ISR_OP_RISE,
      isr_pkg::ISR_QU_ENAB, isr_pkg::ISR_QU_FALL, isr_pkg::ISR_QU_RISE};
   isr_status DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
      .i_constant_current_flag(fl[7]), .i_constant_voltage_flag(fl[6]), .i_trigger_wait_flag(fl[5]),
      .i_regulation_lost_flag(fl[4]), .i_remote_inhibit_flag(fl[3]), .i_thermal_trip_flag(fl[2]),
      .i_current_limit_trip(fl[1]), .i_high_voltage_trip(fl[0]), .o_rd_valid(o_rd_valid),
      .o_rd_data(o_rd_data), .o_op_summary(o_op_summary), .o_qu_summary(o_qu_summary));
   // Random source and expected condition words
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [15:0] opx(input logic [7:0] f);
      return {5'h00, f[7], 1'b0, f[6], 2'b00, f[5], 5'h00};
   endfunction : opx
   function automatic logic [15:0] qux(input logic [7:0] f);
      return {5'h00, f[4], f[3], 4'h0, f[2], 2'b00, f[1], f[0]};
   endfunction : qux
   // One command, one cycle wide, then a gap
   task automatic cmd(input isr_pkg::isr_op_t o, input isr_pkg::isr_sel_t s, input logic [15:0] w);
      @(negedge i_clk);
      i_cmd_valid = 1'b1;
      i_cmd = '{o, s, w};
      @(negedge i_clk);
      i_cmd_valid = 1'b0;
   endtask : cmd
   task automatic rd(input isr_pkg::isr_sel_t s, input logic [15:0] e);
      cmd(isr_pkg::ISR_OP_READ, s, 16'h0000);
      `CHK(s.name(), {1'b1, e}, {o_rd_valid, o_rd_data})
   endtask : rd
   task automatic end_of_test();
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   // Clock and watchdog
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   initial begin
      #200000;
      failures++;
      end_of_test();
   end
   // Main sequence
   initial begin
      fl = 8'h00;
      i_cmd_valid = 1'b0;
      i_cmd = '0;
      i_resetn = 1'b0;
      repeat (8) @(negedge i_clk);
      i_resetn = 1'b1;
      foreach (rw[k]) rd(rw[k], 16'h0000);
      foreach (rw[k]) begin
         v = 16'(xs() % 32728);
         cmd(isr_pkg::ISR_OP_WRITE, rw[k], v);
         rd(rw[k], v);
         cmd(isr_pkg::ISR_OP_WRITE, rw[k], 16'h7fd8);
         rd(rw[k], v);
      end
      cmd(isr_pkg::ISR_OP_WRITE, isr_pkg::ISR_OP_ENAB, isr_pkg::VALUE_MAX);
      rd(isr_pkg::ISR_OP_ENAB, isr_pkg::VALUE_MAX);
      repeat (6) begin
         fl = 8'(xs());
         cmd(isr_pkg::ISR_OP_WRITE, isr_pkg::ISR_OP_COND, 16'hffff);
         rd(isr_pkg::ISR_OP_COND, opx(fl));
         rd(isr_pkg::ISR_QU_COND, qux(fl));
      end
      cmd(isr_pkg::ISR_OP_PRESET, isr_pkg::ISR_OP_COND, 16'h0000);
      rd(isr_pkg::ISR_OP_RISE, isr_pkg::OP_RISE_PRESET);
      rd(isr_pkg::ISR_QU_RISE, isr_pkg::QU_RISE_PRESET);
      rd(isr_pkg::ISR_QU_FALL, 16'h0000);
      // Rising then falling constant current event
      fl = 8'h00;
      cmd(isr_pkg::ISR_OP_WRITE, isr_pkg::ISR_OP_ENAB, isr_pkg::OP_USED);
      cmd(isr_pkg::ISR_OP_READ, isr_pkg::ISR_OP_EVENT, 16'h0000);
      cmd(isr_pkg::ISR_OP_READ, isr_pkg::ISR_QU_EVENT, 16'h0000);
      fl[7] = 1'b1;
      repeat (5) @(negedge i_clk);
      `CHK("op summary", 1'b1, o_op_summary)
      rd(isr_pkg::ISR_OP_EVENT, 16'h0400);
      rd(isr_pkg::ISR_OP_EVENT, 16'h0000);
      `CHK("op summary", 1'b0, o_op_summary)
      cmd(isr_pkg::ISR_OP_WRITE, isr_pkg::ISR_OP_FALL, 16'h0400);
      fl[7] = 1'b0;
      repeat (5) @(negedge i_clk);
      rd(isr_pkg::ISR_OP_EVENT, 16'h0400);
      // Thermal rise, then immediate set on filter write
      fl[2] = 1'b1;
      cmd(isr_pkg::ISR_OP_WRITE, isr_pkg::ISR_QU_ENAB, 16'h0010);
      repeat (5) @(negedge i_clk);
      rd(isr_pkg::ISR_QU_EVENT, 16'h0010);
      rd(isr_pkg::ISR_QU_EVENT, 16'h0000);
      cmd(isr_pkg::ISR_OP_WRITE, isr_pkg::ISR_QU_RISE, 16'h0010);
      @(negedge i_clk);
      `CHK("qu summary", 1'b1, o_qu_summary)
      rd(isr_pkg::ISR_QU_EVENT, 16'h0010);
      // Falling filter written while the pin already sits low
      cmd(isr_pkg::ISR_OP_WRITE, isr_pkg::ISR_QU_ENAB, 16'h0011);
      cmd(isr_pkg::ISR_OP_WRITE, isr_pkg::ISR_QU_FALL, 16'h0001);
      rd(isr_pkg::ISR_QU_EVENT, 16'h0001);
      rd(isr_pkg::isr_sel_t'(4'ha), 16'h0000);
      end_of_test();
   end
endmodule : isr_status_tb
`default_nettype wire
